//--- verilog/iefl_pkg.sv
// Purpose: shared constants for the interrupt enable and flag logic
// Assumes: one clock, 8-bit special-register port from the core
// Notes:   Function list below
//
// Function
// RULE1 - per-source enables plus one global gate
// RULE2 - all enables zero after any reset
// RULE3 - primary enable register bit layout
// RULE4 - secondary enable register bit layout
// RULE5 - flags set regardless of enable
// RULE6 - edge external flag cleared on vectoring
// RULE7 - level external flag follows pin directly
// RULE8 - timer0/1 flag set, cleared by vectoring
// RULE9 - timer2 request ORs two software-cleared flags
// RULE10 - serial request ORs rx and tx flags
// RULE11 - clock monitor flag cleared only by hardware
// RULE12 - adc flag set on valid result, software clears
// RULE13 - pwm flag cleared by software
// RULE14 - low-voltage flag set by hardware, software clears
// RULE15 - timer/external control register bit layout
// RULE16 - ext0/1 sense: 0 level, 1 falling
// RULE17 - run bit stops or starts timer
// RULE18 - ext2 sense: level, fall, rise, both
// RULE19 - software may set timer2 flags any time
// RULE20 - request needs flag, enable and gate
package iefl_pkg;
   // =====================================================
   // register addresses
   localparam logic [7:0] ADDR_TMR_EXT   = 8'h88;
   localparam logic [7:0] ADDR_PRI_EN    = 8'hA8;
   localparam logic [7:0] ADDR_SEC_EN    = 8'hA9;
   localparam logic [7:0] ADDR_EXT2      = 8'hE8;
   localparam logic [7:0] ADDR_TMR2_FLG  = 8'hC8;
   localparam logic [7:0] ADDR_SRC_FLG   = 8'hF0;
   localparam logic [7:0] RESET_VAL      = 8'h00;
   localparam logic [7:0] SEC_EN_MASK    = 8'hB4;
   // =====================================================
   // primary enable fields
   localparam int PE_GATE = 7;
   localparam int PE_ADC  = 6;
   localparam int PE_T2   = 5;
   localparam int PE_UART = 4;
   localparam int PE_T1   = 3;
   localparam int PE_X1   = 2;
   localparam int PE_T0   = 1;
   localparam int PE_X0   = 0;
   // secondary enable fields
   localparam int SE_LPD = 7;
   localparam int SE_PWM = 5;
   localparam int SE_SCM = 4;
   localparam int SE_X2  = 2;
   // timer/external control fields
   localparam int TE_TF1 = 7;
   localparam int TE_TR1 = 6;
   localparam int TE_TF0 = 5;
   localparam int TE_TR0 = 4;
   localparam int TE_IE1 = 3;
   localparam int TE_IT1 = 2;
   localparam int TE_IE0 = 1;
   localparam int TE_IT0 = 0;
   // ext2 register fields
   localparam int X2_SEL_LO = 2;
   localparam int X2_REQ    = 0;
   // timer2 flag fields
   localparam int T2_OVF = 7;
   localparam int T2_EXT = 6;
   // peripheral flag register fields (software side)
   localparam int SF_RX  = 0;
   localparam int SF_TX  = 1;
   localparam int SF_SCM = 2;
   localparam int SF_ADC = 3;
   localparam int SF_PWM = 4;
   localparam int SF_LPD = 5;
   // =====================================================
   // source indices of the request vector
   localparam int NSRC    = 11;
   localparam int SRC_X0  = 0;
   localparam int SRC_T0  = 1;
   localparam int SRC_X1  = 2;
   localparam int SRC_T1  = 3;
   localparam int SRC_UART = 4;
   localparam int SRC_T2  = 5;
   localparam int SRC_ADC = 6;
   localparam int SRC_X2  = 7;
   localparam int SRC_SCM = 8;
   localparam int SRC_PWM = 9;
   localparam int SRC_LPD = 10;

   typedef enum logic [1:0] {
      X2_LEVEL = 2'b00,
      X2_FALL  = 2'b01,
      X2_RISE  = 2'b10,
      X2_BOTH  = 2'b11
   } iefl_x2sel_t;
endpackage

//--- verilog/iefl_link_if.sv
`timescale 1ns/1ps
// Purpose: joins the interrupt logic and the core vectoring end
// Assumes: single clock domain
// Notes:   none
interface iefl_link_if;
   logic [10:0] irqReq;
   logic [10:0] vecAck;
   logic        sfrWr;
   logic        sfrRd;
   logic [7:0]  sfrAddr;
   logic [7:0]  sfrWdata;
   logic [7:0]  sfrRdata;
   modport device (
      input  vecAck, sfrWr, sfrRd, sfrAddr, sfrWdata,
      output irqReq, sfrRdata
   );
   modport core (
      output vecAck, sfrWr, sfrRd, sfrAddr, sfrWdata,
      input  irqReq, sfrRdata
   );
endinterface

//--- verilog/iefl_ext_sense.sv
`timescale 1ns/1ps
// Purpose: synchronise one external request pin and detect edges
// Assumes: pin is asynchronous to core_clk, active low
// Notes:   outputs are single-cycle pulses except the level
module iefl_ext_sense (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic reset,
   // pin
   input  wire logic pinN,
   // detections
   output logic      lvlActive,
   output logic      fallSeen,
   output logic      riseSeen
);
   logic sync1_r, sync2_r, prev_r;
   logic sync1_nxt, sync2_nxt, prev_nxt;

   always_comb begin
      sync1_nxt = pinN;
      sync2_nxt = sync1_r;
      prev_nxt  = sync2_r;
   end

   // idle pin is high, so the chain resets to one to avoid a false edge
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
         prev_r  <= 1'b1;
      end else begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         prev_r  <= prev_nxt;
      end
   end

   assign lvlActive = ~sync2_r;
   assign fallSeen  = prev_r & ~sync2_r;
   assign riseSeen  = ~prev_r & sync2_r;
endmodule

//--- verilog/iefl_irq_ctrl.sv
`timescale 1ns/1ps
// Purpose: interrupt enables, request flags and qualified requests
// Assumes: core reads/writes special registers one byte per cycle
// Notes:   vecAck bit pulses one cycle when a routine is entered
module iefl_irq_ctrl
   import iefl_pkg::*;
(
   // clock and reset
   input  wire logic  core_clk,
   input  wire logic  reset,
   // core side
   iefl_link_if.device link,
   // external pins, active low
   input  wire logic  ext0PinN,
   input  wire logic  ext1PinN,
   input  wire logic  ext2PinN,
   // peripheral event pulses
   input  wire logic  tmr0Ovf,
   input  wire logic  tmr1Ovf,
   input  wire logic  tmr2Ovf,
   input  wire logic  tmr2Ext,
   input  wire logic  uartRx,
   input  wire logic  uartTx,
   input  wire logic  clkmonSet,
   input  wire logic  clkmonClr,
   input  wire logic  adcDone,
   input  wire logic  adcCmpMode,
   input  wire logic  adcAboveCmp,
   input  wire logic  pwmEvent,
   input  wire logic  lowvoltEvent,
   // timer run controls
   output logic       tmr0Run,
   output logic       tmr1Run
);
   // =====================================================
   // registers
   logic [7:0] priEn_r, priEn_nxt;
   logic [7:0] secEn_r, secEn_nxt;
   logic [7:0] tmrExt_r, tmrExt_nxt;
   logic [1:0] x2Sel_r, x2Sel_nxt;
   logic       x2Req_r, x2Req_nxt;
   logic       t2Ovf_r, t2Ovf_nxt;
   logic       t2Ext_r, t2Ext_nxt;
   logic [5:0] srcFlg_r, srcFlg_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [10:0] req_r, req_nxt;

   logic lvl0, fall0, lvl1, fall1, lvl2, fall2, rise2;
   logic x2EdgeHit;

   iefl_ext_sense u_x0 (
      .core_clk  (core_clk),
      .reset     (reset),
      .pinN      (ext0PinN),
      .lvlActive (lvl0),
      .fallSeen  (fall0),
      .riseSeen  ()
   );
   iefl_ext_sense u_x1 (
      .core_clk  (core_clk),
      .reset     (reset),
      .pinN      (ext1PinN),
      .lvlActive (lvl1),
      .fallSeen  (fall1),
      .riseSeen  ()
   );
   iefl_ext_sense u_x2 (
      .core_clk  (core_clk),
      .reset     (reset),
      .pinN      (ext2PinN),
      .lvlActive (lvl2),
      .fallSeen  (fall2),
      .riseSeen  (rise2)
   );

   function automatic logic wrHit(input logic [7:0] a);
      wrHit = link.sfrWr && (link.sfrAddr == a);
   endfunction

   // edge-flag update: set beats clear, vectoring clears
   function automatic logic edgeFlag(input logic cur, input logic set,
                                     input logic swWr, input logic swVal,
                                     input logic ack);
      logic v;
      v = cur;
      if (swWr) begin
         v = swVal;
      end
      if (ack) begin
         v = 1'b0;
      end
      edgeFlag = v | set;
   endfunction

   always_comb begin
      unique case (iefl_x2sel_t'(x2Sel_r))
         X2_FALL: x2EdgeHit = fall2;
         X2_RISE: x2EdgeHit = rise2;
         X2_BOTH: x2EdgeHit = fall2 | rise2;
         X2_LEVEL: x2EdgeHit = 1'b0;
      endcase
   end

   // =====================================================
   // next-state
   always_comb begin
      logic wTe;
      logic [7:0] wd;
      wTe = wrHit(ADDR_TMR_EXT);
      wd  = link.sfrWdata;
      priEn_nxt = wrHit(ADDR_PRI_EN) ? wd : priEn_r;           // [RULE3]
      secEn_nxt = wrHit(ADDR_SEC_EN) ? (wd & SEC_EN_MASK)
                                     : secEn_r;                // [RULE4]
      tmrExt_nxt = tmrExt_r;
      if (wTe) begin
         tmrExt_nxt[TE_TR1] = wd[TE_TR1];                      // [RULE15]
         tmrExt_nxt[TE_TR0] = wd[TE_TR0];
         tmrExt_nxt[TE_IT1] = wd[TE_IT1];
         tmrExt_nxt[TE_IT0] = wd[TE_IT0];
      end
      // timer flags set on overflow, cleared on vectoring  [RULE8] [RULE5]
      tmrExt_nxt[TE_TF0] = edgeFlag(tmrExt_r[TE_TF0], tmr0Ovf, wTe,
                                    wd[TE_TF0], link.vecAck[SRC_T0]);
      tmrExt_nxt[TE_TF1] = edgeFlag(tmrExt_r[TE_TF1], tmr1Ovf, wTe,
                                    wd[TE_TF1], link.vecAck[SRC_T1]);
      // ext0/1: falling edge latches, low level follows pin [RULE16]
      if (tmrExt_r[TE_IT0]) begin
         tmrExt_nxt[TE_IE0] = edgeFlag(tmrExt_r[TE_IE0], fall0, wTe,
                                       wd[TE_IE0],
                                       link.vecAck[SRC_X0]);   // [RULE6]
      end else begin
         tmrExt_nxt[TE_IE0] = lvl0;                            // [RULE7]
      end
      if (tmrExt_r[TE_IT1]) begin
         tmrExt_nxt[TE_IE1] = edgeFlag(tmrExt_r[TE_IE1], fall1, wTe,
                                       wd[TE_IE1],
                                       link.vecAck[SRC_X1]);   // [RULE6]
      end else begin
         tmrExt_nxt[TE_IE1] = lvl1;                            // [RULE7]
      end
      // ext2 [RULE18]
      x2Sel_nxt = wrHit(ADDR_EXT2) ? wd[X2_SEL_LO +: 2] : x2Sel_r;
      if (x2Sel_r == X2_LEVEL) begin
         x2Req_nxt = lvl2;                                     // [RULE7]
      end else begin
         x2Req_nxt = edgeFlag(x2Req_r, x2EdgeHit, wrHit(ADDR_EXT2),
                              wd[X2_REQ], link.vecAck[SRC_X2]); // [RULE6]
      end
      // timer2 flags: software sets or clears, vectoring leaves them
      t2Ovf_nxt = t2Ovf_r;
      t2Ext_nxt = t2Ext_r;
      if (wrHit(ADDR_TMR2_FLG)) begin
         t2Ovf_nxt = wd[T2_OVF];                               // [RULE19]
         t2Ext_nxt = wd[T2_EXT];
      end
      t2Ovf_nxt = t2Ovf_nxt | tmr2Ovf;                         // [RULE9]
      t2Ext_nxt = t2Ext_nxt | tmr2Ext;
      // remaining peripheral flags, software clears all but the clock monitor flag by writing zero
      srcFlg_nxt = srcFlg_r;
      if (wrHit(ADDR_SRC_FLG)) begin
         srcFlg_nxt = srcFlg_r & wd[5:0];
         srcFlg_nxt[SF_SCM] = srcFlg_r[SF_SCM];                // [RULE11]
      end
      if (clkmonClr) begin
         srcFlg_nxt[SF_SCM] = 1'b0;
      end
      srcFlg_nxt[SF_RX]  = srcFlg_nxt[SF_RX] | uartRx;         // [RULE10]
      srcFlg_nxt[SF_TX]  = srcFlg_nxt[SF_TX] | uartTx;
      srcFlg_nxt[SF_SCM] = srcFlg_nxt[SF_SCM] | clkmonSet;     // [RULE11]
      srcFlg_nxt[SF_ADC] = srcFlg_nxt[SF_ADC]
                         | (adcDone & (~adcCmpMode | adcAboveCmp)); // [RULE12]
      srcFlg_nxt[SF_PWM] = srcFlg_nxt[SF_PWM] | pwmEvent;      // [RULE13]
      srcFlg_nxt[SF_LPD] = srcFlg_nxt[SF_LPD] | lowvoltEvent;  // [RULE14]
      // qualified requests [RULE20] [RULE1]
      req_nxt = '0;
      if (priEn_r[PE_GATE]) begin
         req_nxt[SRC_X0]  = tmrExt_r[TE_IE0] & priEn_r[PE_X0];
         req_nxt[SRC_T0]  = tmrExt_r[TE_TF0] & priEn_r[PE_T0];
         req_nxt[SRC_X1]  = tmrExt_r[TE_IE1] & priEn_r[PE_X1];
         req_nxt[SRC_T1]  = tmrExt_r[TE_TF1] & priEn_r[PE_T1];
         req_nxt[SRC_UART] = (srcFlg_r[SF_RX] | srcFlg_r[SF_TX])
                           & priEn_r[PE_UART];                 // [RULE10]
         req_nxt[SRC_T2]  = (t2Ovf_r | t2Ext_r) & priEn_r[PE_T2]; // [RULE9]
         req_nxt[SRC_ADC] = srcFlg_r[SF_ADC] & priEn_r[PE_ADC];
         req_nxt[SRC_X2]  = x2Req_r & secEn_r[SE_X2];
         req_nxt[SRC_SCM] = srcFlg_r[SF_SCM] & secEn_r[SE_SCM];
         req_nxt[SRC_PWM] = srcFlg_r[SF_PWM] & secEn_r[SE_PWM];
         req_nxt[SRC_LPD] = srcFlg_r[SF_LPD] & secEn_r[SE_LPD];
      end
      // read data, unmapped reads as zero
      rdata_nxt = RESET_VAL;
      if (link.sfrRd) begin
         unique case (link.sfrAddr)
            ADDR_TMR_EXT:  rdata_nxt = tmrExt_r;
            ADDR_PRI_EN:   rdata_nxt = priEn_r;
            ADDR_SEC_EN:   rdata_nxt = secEn_r;
            ADDR_EXT2:     rdata_nxt = {4'h0, x2Sel_r, 1'b0, x2Req_r};
            ADDR_TMR2_FLG: rdata_nxt = {t2Ovf_r, t2Ext_r, 6'h00};
            ADDR_SRC_FLG:  rdata_nxt = {2'b00, srcFlg_r};
            default:       rdata_nxt = RESET_VAL;
         endcase
      end
   end

   // =====================================================
   // state registers, all cleared by reset [RULE2]
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         priEn_r  <= RESET_VAL;
         secEn_r  <= RESET_VAL;
         tmrExt_r <= RESET_VAL;
         x2Sel_r  <= 2'h0;
         x2Req_r  <= 1'b0;
         t2Ovf_r  <= 1'b0;
         t2Ext_r  <= 1'b0;
         srcFlg_r <= 6'h00;
         rdata_r  <= RESET_VAL;
         req_r    <= 11'h000;
      end else begin
         priEn_r  <= priEn_nxt;
         secEn_r  <= secEn_nxt;
         tmrExt_r <= tmrExt_nxt;
         x2Sel_r  <= x2Sel_nxt;
         x2Req_r  <= x2Req_nxt;
         t2Ovf_r  <= t2Ovf_nxt;
         t2Ext_r  <= t2Ext_nxt;
         srcFlg_r <= srcFlg_nxt;
         rdata_r  <= rdata_nxt;
         req_r    <= req_nxt;
      end
   end

   assign link.irqReq   = req_r;
   assign link.sfrRdata = rdata_r;
   assign tmr0Run = tmrExt_r[TE_TR0];                          // [RULE17]
   assign tmr1Run = tmrExt_r[TE_TR1];                          // [RULE17]
endmodule

//--- verilog/iefl_core_end.sv
`timescale 1ns/1ps
// Purpose: core-side end: register access and vectoring acknowledge
// Assumes: user asks one register access at a time
// Notes:   acknowledges the lowest-numbered pending request
module iefl_core_end
   import iefl_pkg::*;
(
   // clock and reset
   input  wire logic  core_clk,
   input  wire logic  reset,
   // link
   iefl_link_if.core  link,
   // user register port
   input  wire logic  userWr,
   input  wire logic  userRd,
   input  wire logic [7:0] userAddr,
   input  wire logic [7:0] userWdata,
   output logic [7:0] userRdata,
   // vectoring control
   input  wire logic  vecAllow,
   output logic [10:0] vecTaken
);
   typedef enum logic [2:0] {
      CE_IDLE = 3'b001,
      CE_HOLD = 3'b010,
      CE_WAIT = 3'b100
   } iefl_ce_t;

   iefl_ce_t    st_r, st_nxt;
   logic [10:0] ack_r, ack_nxt;
   logic [7:0]  rd_r, rd_nxt;
   logic        rdPend_r, rdPend_nxt;

   function automatic logic [10:0] lowestOne(input logic [10:0] v);
      lowestOne = v & (~v + 11'h001);
   endfunction

   // after an acknowledge wait two cycles: one for the flag to clear and
   // one for the registered request to follow, so no double vectoring
   always_comb begin
      st_nxt  = st_r;
      ack_nxt = 11'h000;
      unique case (st_r)
         CE_IDLE: begin
            if (vecAllow && (link.irqReq != 11'h000)) begin
               ack_nxt = lowestOne(link.irqReq);
               st_nxt  = CE_HOLD;
            end
         end
         CE_HOLD: begin
            st_nxt = CE_WAIT;
         end
         CE_WAIT: begin
            st_nxt = CE_IDLE;
         end
         default: begin
            st_nxt = CE_IDLE;
         end
      endcase
      rdPend_nxt = userRd;
      rd_nxt = rdPend_r ? link.sfrRdata : rd_r;
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         st_r     <= CE_IDLE;
         ack_r    <= 11'h000;
         rd_r     <= 8'h00;
         rdPend_r <= 1'b0;
      end else begin
         st_r     <= st_nxt;
         ack_r    <= ack_nxt;
         rd_r     <= rd_nxt;
         rdPend_r <= rdPend_nxt;
      end
   end

   assign link.vecAck   = ack_r;
   assign link.sfrWr    = userWr;
   assign link.sfrRd    = userRd;
   assign link.sfrAddr  = userAddr;
   assign link.sfrWdata = userWdata;
   assign userRdata     = rd_r;
   assign vecTaken      = ack_r;
endmodule

//--- sim/iefl_irq_chk.sv
// Purpose: concurrent checks on the link between the two ends
// Assumes: one clock; reset high asynchronous
// Notes:   enables and sense bits are mirrored from the write stream
`timescale 1ns/1ps
module iefl_irq_chk
   import iefl_pkg::*;
(
   // clock and reset
   input wire logic        core_clk,
   input wire logic        reset,
   // link signals
   input wire logic [10:0] irqReq,
   input wire logic [10:0] vecAck,
   input wire logic        sfrWr,
   input wire logic        sfrRd,
   input wire logic [7:0]  sfrAddr,
   input wire logic [7:0]  sfrWdata,
   input wire logic [7:0]  sfrRdata
);
   // ==========================================================
   // mirrors of plain read/write bits
   logic [7:0]  priEn_r;
   logic [7:0]  priEn_nxt;
   logic [7:0]  secEn_r;
   logic [7:0]  secEn_nxt;
   logic [1:0]  sense_r;
   logic [1:0]  sense_nxt;
   logic [10:0] enV;
   logic        mapped;
   always_comb begin
      priEn_nxt = priEn_r;
      secEn_nxt = secEn_r;
      sense_nxt = sense_r;
      if (sfrWr && sfrAddr == ADDR_PRI_EN) begin
         priEn_nxt = sfrWdata;
      end
      if (sfrWr && sfrAddr == ADDR_SEC_EN) begin
         secEn_nxt = sfrWdata & SEC_EN_MASK;
      end
      if (sfrWr && sfrAddr == ADDR_TMR_EXT) begin
         sense_nxt = {sfrWdata[TE_IT1], sfrWdata[TE_IT0]};
      end
   end
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         priEn_r <= 8'h00;
         secEn_r <= 8'h00;
         sense_r <= 2'h0;
      end else begin
         priEn_r <= priEn_nxt;
         secEn_r <= secEn_nxt;
         sense_r <= sense_nxt;
      end
   end
   assign enV = {secEn_r[SE_LPD], secEn_r[SE_PWM], secEn_r[SE_SCM],
                 secEn_r[SE_X2], priEn_r[6:0]};
   assign mapped = sfrAddr inside {ADDR_TMR_EXT, ADDR_PRI_EN, ADDR_SEC_EN,
                                   ADDR_EXT2, ADDR_TMR2_FLG, ADDR_SRC_FLG};
   // ==========================================================
   // assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   a_reset_quiet: assert property ($fell(reset) |-> irqReq == '0)
      else $error("request seen right after reset");
   a_rdata_idle: assert property (!$past(sfrRd) |-> sfrRdata == 8'h00)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (sfrRd && !mapped |=> sfrRdata == 8'h00)
      else $error("unmapped address read not zero");
   a_pri_readback: assert property (sfrRd && sfrAddr == ADDR_PRI_EN
      |=> sfrRdata == $past(priEn_r)) else $error("primary enable readback");
   a_sec_readback: assert property (sfrRd && sfrAddr == ADDR_SEC_EN
      |=> sfrRdata == $past(secEn_r)) else $error("secondary enable readback");
   a_gate_blocks: assert property (!priEn_r[PE_GATE] &&
      !$past(priEn_r[PE_GATE]) |-> irqReq == 11'h000)
      else $error("request passed a closed gate");
   a_req_needs_en: assert property (
      (irqReq & ~enV & ~$past(enV)) == 11'h000)
      else $error("request on a disabled source");
   a_ack_pending: assert property (vecAck != 11'h000 |->
      $onehot(vecAck) && (vecAck & ~$past(irqReq)) == 11'h000)
      else $error("vectoring without a pending request");
   a_t0_vec_clear: assert property (vecAck[SRC_T0] |->
      ##[1:3] !irqReq[SRC_T0]) else $error("timer0 flag kept on vectoring");
   a_x1_edge_clear: assert property (vecAck[SRC_X1] && sense_r[1] |->
      ##[1:3] !irqReq[SRC_X1]) else $error("ext1 edge flag kept");
   a_x0_level_keep: assert property (vecAck[SRC_X0] && !sense_r[0] |=>
      irqReq[SRC_X0]) else $error("ext0 level flag cleared by vectoring");
   a_uart_kept: assert property (vecAck[SRC_UART] ##1 !sfrWr [*3] |->
      irqReq[SRC_UART]) else $error("serial flag cleared by vectoring");
   c_uart_vec: cover property (vecAck[SRC_UART]);
   c_sec_read: cover property (sfrRd && sfrAddr == ADDR_SEC_EN);
   c_level_req: cover property (irqReq[SRC_X0] && !sense_r[0]);
endmodule

//--- sim/test_irq_enable_and_flag_logic.sv
// Purpose: scenario bench for both ends joined by the link
// Assumes: inputs change at the falling edge
// Notes:   event bits: 0 t0,1 t1,2 t2ovf,3 t2ext,4 rx,5 tx,6 scmset,
//          7 scmclr,8 adc,9 pwm,10 lowvolt
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin \
   n_errors++; $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module test_irq_enable_and_flag_logic
   import iefl_pkg::*;
;
   logic        core_clk = 1'b0;
   logic        reset = 1'b1;
   logic [2:0]  pinN = 3'b111;
   logic [10:0] ev = 11'h000;
   logic        adcCmpMode = 1'b0;
   logic        adcAboveCmp = 1'b0;
   logic        userWr = 1'b0;
   logic        userRd = 1'b0;
   logic        vecAllow = 1'b0;
   logic [7:0]  userAddr = 8'h00;
   logic [7:0]  userWdata = 8'h00;
   logic [7:0]  userRdata;
   logic [10:0] vecTaken;
   logic        tmr0Run;
   logic        tmr1Run;
   int          n_errors = 0;
   int          check_count = 0;
   // ==========================================================
   // ends and checker
   iefl_link_if link ();
   iefl_irq_ctrl i_iefl_irq_ctrl (.core_clk(core_clk), .reset(reset),
      .link(link.device), .ext0PinN(pinN[0]), .ext1PinN(pinN[1]),
      .ext2PinN(pinN[2]), .tmr0Ovf(ev[0]), .tmr1Ovf(ev[1]),
      .tmr2Ovf(ev[2]), .tmr2Ext(ev[3]), .uartRx(ev[4]), .uartTx(ev[5]),
      .clkmonSet(ev[6]), .clkmonClr(ev[7]), .adcDone(ev[8]),
      .adcCmpMode(adcCmpMode), .adcAboveCmp(adcAboveCmp),
      .pwmEvent(ev[9]), .lowvoltEvent(ev[10]), .tmr0Run(tmr0Run),
      .tmr1Run(tmr1Run));
   iefl_core_end i_iefl_core_end (.core_clk(core_clk), .reset(reset),
      .link(link.core), .userWr(userWr), .userRd(userRd),
      .userAddr(userAddr), .userWdata(userWdata), .userRdata(userRdata),
      .vecAllow(vecAllow), .vecTaken(vecTaken));
   iefl_irq_chk i_iefl_irq_chk (.core_clk(core_clk), .reset(reset),
      .irqReq(link.irqReq), .vecAck(link.vecAck), .sfrWr(link.sfrWr),
      .sfrRd(link.sfrRd), .sfrAddr(link.sfrAddr),
      .sfrWdata(link.sfrWdata), .sfrRdata(link.sfrRdata));
   always #2 core_clk = ~core_clk;
   // ==========================================================
   // shared tasks
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      userWr = 1'b1;
      userAddr = a;
      userWdata = d;
      @(negedge core_clk);
      userWr = 1'b0;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [7:0] m,
                        input logic [7:0] e);
      @(negedge core_clk);
      userRd = 1'b1;
      userAddr = a;
      @(negedge core_clk);
      userRd = 1'b0;
      repeat (2) @(negedge core_clk);
      `CHK("register read", e, userRdata & m);
   endtask
   task automatic pulse(input int b);
      @(negedge core_clk);
      ev[b] = 1'b1;
      @(negedge core_clk);
      ev[b] = 1'b0;
   endtask
   task automatic settle();
      repeat (6) @(negedge core_clk);
   endtask
   // bounded wait: a missing acknowledge must not hang the run
   task automatic vec(input int s);
      int k;
      k = 0;
      @(negedge core_clk);
      vecAllow = 1'b1;
      while (vecTaken === 11'h000 && k < 10) begin
         @(negedge core_clk);
         k++;
      end
      vecAllow = 1'b0;
      `CHK("vecTaken", 11'h001 << s, vecTaken);
      settle();
   endtask
   // ==========================================================
   // scenarios
   task automatic t_regs();
      rdChk(ADDR_TMR_EXT, 8'hFF, 8'h00);
      rdChk(ADDR_PRI_EN, 8'hFF, 8'h00);
      rdChk(ADDR_SEC_EN, 8'hFF, 8'h00);
      wr(ADDR_PRI_EN, 8'hFF);
      rdChk(ADDR_PRI_EN, 8'hFF, 8'hFF);
      wr(ADDR_SEC_EN, 8'hFF);
      rdChk(ADDR_SEC_EN, 8'hFF, 8'hB4);
      wr(ADDR_TMR_EXT, 8'h55);
      rdChk(ADDR_TMR_EXT, 8'hFF, 8'h55);
      `CHK("run bits", 2'b11, {tmr1Run, tmr0Run});
      wr(ADDR_TMR_EXT, 8'h00);
      `CHK("run bits", 2'b00, {tmr1Run, tmr0Run});
      rdChk(8'h3C, 8'hFF, 8'h00);
      wr(ADDR_PRI_EN, 8'h00);
      wr(ADDR_SEC_EN, 8'h00);
   endtask
   task automatic t_tmr0();
      pulse(0);
      rdChk(ADDR_TMR_EXT, 8'h20, 8'h20);
      wr(ADDR_PRI_EN, 8'h02);
      settle();
      `CHK("t0 gated", 1'b0, link.irqReq[SRC_T0]);
      wr(ADDR_PRI_EN, 8'h82);
      settle();
      `CHK("t0 req", 1'b1, link.irqReq[SRC_T0]);
      vec(SRC_T0);
      rdChk(ADDR_TMR_EXT, 8'h20, 8'h00);
   endtask
   task automatic t_uart_t2();
      wr(ADDR_PRI_EN, 8'h90);
      pulse(4);
      settle();
      vec(SRC_UART);
      `CHK("uart kept", 1'b1, link.irqReq[SRC_UART]);
      wr(ADDR_SRC_FLG, 8'h3E);
      settle();
      `CHK("uart clear", 1'b0, link.irqReq[SRC_UART]);
      wr(ADDR_PRI_EN, 8'hA0);
      wr(ADDR_TMR2_FLG, 8'h80);
      settle();
      vec(SRC_T2);
      `CHK("t2 kept", 1'b1, link.irqReq[SRC_T2]);
      wr(ADDR_TMR2_FLG, 8'h00);
      pulse(3);
      rdChk(ADDR_TMR2_FLG, 8'hC0, 8'h40);
      wr(ADDR_TMR2_FLG, 8'h00);
   endtask
   task automatic t_flags();
      int evs[5] = '{5, 8, 9, 10, 4};
      foreach (evs[i]) pulse(evs[i]);
      rdChk(ADDR_SRC_FLG, 8'h3F, 8'h3B);
      wr(ADDR_SEC_EN, 8'hA0);
      wr(ADDR_PRI_EN, 8'h80);
      settle();
      `CHK("pwm lpd req", 2'b11, link.irqReq[10:9]);
      wr(ADDR_SRC_FLG, 8'h00);
      settle();
      `CHK("pwm lpd clr", 2'b00, link.irqReq[10:9]);
      adcCmpMode = 1'b1;
      pulse(8);
      rdChk(ADDR_SRC_FLG, 8'h08, 8'h00);
      adcAboveCmp = 1'b1;
      pulse(8);
      rdChk(ADDR_SRC_FLG, 8'h08, 8'h08);
      pulse(6);
      wr(ADDR_PRI_EN, 8'hC0);
      wr(ADDR_SEC_EN, 8'h10);
      settle();
      `CHK("adc scm", 2'b11, {link.irqReq[8], link.irqReq[6]});
      wr(ADDR_SRC_FLG, 8'h00);
      rdChk(ADDR_SRC_FLG, 8'h0C, 8'h04);
      pulse(7);
      rdChk(ADDR_SRC_FLG, 8'h04, 8'h00);
   endtask
   task automatic t_ext();
      wr(ADDR_PRI_EN, 8'h85);
      pinN[0] = 1'b0;
      settle();
      vec(SRC_X0);
      `CHK("x0 level kept", 1'b1, link.irqReq[SRC_X0]);
      pinN[0] = 1'b1;
      settle();
      `CHK("x0 follows pin", 1'b0, link.irqReq[SRC_X0]);
      wr(ADDR_TMR_EXT, 8'h04);
      pinN[1] = 1'b0;
      settle();
      vec(SRC_X1);
      `CHK("x1 edge clear", 1'b0, link.irqReq[SRC_X1]);
      pinN[1] = 1'b1;
      pinN[2] = 1'b0;
      for (int m = 0; m < 4; m++) begin
         wr(ADDR_EXT2, {4'h0, 2'(m), 2'b00});
         // leaving level mode keeps the pin's flag, so clear it again
         wr(ADDR_EXT2, {4'h0, 2'(m), 2'b00});
         settle();
         pinN[2] = 1'b1;
         settle();
         rdChk(ADDR_EXT2, 8'h01, 8'((4'b1100 >> m) & 4'h1));
         wr(ADDR_EXT2, {4'h0, 2'(m), 2'b00});
         settle();
         pinN[2] = 1'b0;
         settle();
         rdChk(ADDR_EXT2, 8'h01, 8'((4'b1011 >> m) & 4'h1));
      end
      wr(ADDR_SEC_EN, 8'h04);
      settle();
      vec(SRC_X2);
      rdChk(ADDR_EXT2, 8'h01, 8'h00);
   endtask
   // ==========================================================
   // run control
   task automatic summarize();
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(negedge core_clk);
      reset = 1'b0;
      t_regs();
      t_tmr0();
      t_uart_t2();
      t_flags();
      t_ext();
      summarize();
   end
   // tests need about 420 cycles; the 10000-cycle watchdog leaves a generous margin
   initial begin
      #40000;
      n_errors++;
      $display("[FAIL] watchdog expected done seen hang");
      summarize();
   end
endmodule
